// *** rtl/cmm_pkg.sv ***
// constants for the core memory map decode
package cmm_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int PC_W = 13;
   localparam int PM_AW = 11;
   localparam int PM_DW = 14;
   localparam int DA_W = 9;
   localparam int OFS_W = 7;
   localparam int GPR_DEPTH = 128;
   localparam int GPR_AW = 7;
   // ----------------------------------------
   // vectors and reset values
   // ----------------------------------------
   localparam logic [12:0] RESET_VEC = 13'h0000;
   localparam logic [12:0] IRQ_VEC = 13'h0004;
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [4:0] LATCH_RST = 5'h00;
   localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
   // ----------------------------------------
   // register offsets, answered in banks 0 and 1
   // ----------------------------------------
   localparam logic [6:0] OFS_INDIRECT = 7'h00;
   localparam logic [6:0] OFS_PCL = 7'h02;
   localparam logic [6:0] OFS_STATUS = 7'h03;
   localparam logic [6:0] OFS_PTR = 7'h04;
   localparam logic [6:0] OFS_LATCH = 7'h0a;
   localparam logic [6:0] OFS_INTERRUPT_CONTROL = 7'h0b;
   // ----------------------------------------
   // status fields and general purpose ram windows
   // ----------------------------------------
   localparam int ST_BANK_HI = 6;
   localparam int ST_BANK_LO = 5;
   localparam int ST_IND_HI = 7;
   localparam logic [7:0] ST_WMASK = 8'he7;
   localparam logic [6:0] GPR0_LO = 7'h20;
   localparam logic [6:0] GPR1_LO = 7'h20;
   localparam logic [6:0] GPR1_HI = 7'h3f;
   localparam logic [6:0] GPR1_BASE = 7'h60;
endpackage

// *** rtl/cmm_gpr_ram.sv ***
// general purpose register storage, static, no reset
`timescale 1ns/1ps
module cmm_gpr_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128,
   parameter int AW = 7
)(
   input wire logic core_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   // contents hold with no refresh, also while the clock is stopped
   always_ff @(posedge core_clk)
   begin
      if (wr_en)
      begin
         mem_r[waddr] <= wdata;
      end
   end

   // asynchronous read; the caller registers it
   assign rdata = mem_r[raddr];
endmodule

// *** rtl/cmm_prog_store.sv ***
// program word store with its own load port and registered fetch
`timescale 1ns/1ps
module cmm_prog_store #(
   parameter int AW = 11,
   parameter int DW = 14
)(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic load_en,
   input wire logic [AW-1:0] load_addr,
   input wire logic [DW-1:0] load_data,
   input wire logic [AW-1:0] fetch_addr,
   output logic [DW-1:0] fetch_word_r
);
   logic [DW-1:0] mem_r [2**AW];

   // image load, separate from the fetch path
   always_ff @(posedge core_clk)
   begin
      if (load_en)
      begin
         mem_r[load_addr] <= load_data;
      end
   end

   // one fetch per cycle
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         fetch_word_r <= '0;
      end
      else
      begin
         fetch_word_r <= mem_r[fetch_addr];
      end
   end
endmodule

// *** rtl/cmm_core_mem.sv ***
// core memory map: program counter, fetch, data banks and core registers
//
// Functional notes
// - Program and data memory have separate ports, so one access to each fits in a cycle.
// - A 13-bit program counter fetches from a 2K x 14 store at 0000h to 07FFh.
// - Addresses above 07FFh wrap into the store instead of faulting.
// - Reset starts at address 0 and an accepted interrupt branches to address 4.
// - Status bits 6:5 pick the direct bank; 00 is bank 0, 01 bank 1, 10 and 11 unused.
// - Each bank is a 7-bit offset space of 128 bytes topped by the bank-select bits.
// - Core registers sit at the low offsets and general purpose RAM above them.
// - General purpose RAM is static storage with no refresh.
// - Busy core registers such as status answer in more than one bank.
// - Locations are reached by a direct offset or through the indirect pointer.
`timescale 1ns/1ps
module cmm_core_mem #(
   parameter int GPR_WORDS = 128
)(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic pc_step,
   input wire logic pc_load,
   input wire logic [cmm_pkg::PC_W-1:0] pc_load_val,
   input wire logic irq_take,
   input wire logic pm_load,
   input wire logic [cmm_pkg::PM_AW-1:0] pm_load_addr,
   input wire logic [cmm_pkg::PM_DW-1:0] pm_load_data,
   input wire logic [cmm_pkg::OFS_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic [cmm_pkg::PC_W-1:0] pc,
   output logic [cmm_pkg::PM_DW-1:0] instr_word,
   output logic [1:0] bank_sel,
   output logic [7:0] interrupt_control
);
   import cmm_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [PC_W-1:0] pc_r;
   logic [7:0] core_status_r;
   logic [7:0] indirect_pointer_r;
   logic [4:0] pc_upper_latch_r;
   logic [7:0] interrupt_control_r;
   logic [7:0] reg_rdata_r;
   logic [DA_W-1:0] data_addr;
   logic [OFS_W-1:0] ofs;
   logic [1:0] bank;
   logic bank_ok;
   logic is_core;
   logic gpr_hit;
   logic [GPR_AW-1:0] gpr_idx;
   logic [7:0] gpr_rdata;
   logic [7:0] rd_value;
   logic gpr_wr;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // the indirect port swaps in the pointer plus the upper status bit
   always_comb
   begin
      if (reg_addr == OFS_INDIRECT)
      begin
         data_addr = {core_status_r[ST_IND_HI], indirect_pointer_r};
      end
      else
      begin
         data_addr = {core_status_r[ST_BANK_HI:ST_BANK_LO], reg_addr};
      end
   end

   assign ofs = data_addr[OFS_W-1:0];
   assign bank = data_addr[DA_W-1:OFS_W];
   // banks 2 and 3 decode to nothing; software keeps the high bit clear
   assign bank_ok = (bank[1] == 1'b0);

   // core registers mirror in both implemented banks
   always_comb
   begin
      case (ofs)
         OFS_INDIRECT, OFS_PCL, OFS_STATUS, OFS_PTR, OFS_LATCH, OFS_INTERRUPT_CONTROL:
            is_core = bank_ok;
         default:
            is_core = 1'b0;
      endcase
   end

   // ram above the core registers; bank 1 window is shorter
   always_comb
   begin
      gpr_hit = 1'b0;
      gpr_idx = '0;
      if (bank_ok && !bank[0] && ofs >= GPR0_LO)
      begin
         gpr_hit = 1'b1;
         gpr_idx = ofs - GPR0_LO;
      end
      else if (bank_ok && bank[0] && ofs >= GPR1_LO && ofs <= GPR1_HI)
      begin
         gpr_hit = 1'b1;
         gpr_idx = GPR1_BASE + (ofs - GPR1_LO);
      end
   end

   // an indirect access that itself points at the port has no target
   assign gpr_wr = reg_wr && gpr_hit;

   // ----------------------------------------
   // general purpose ram
   // ----------------------------------------
   cmm_gpr_ram #(
      .WIDTH(8),
      .DEPTH(GPR_WORDS),
      .AW(GPR_AW)
   ) u_gpr (
      .core_clk(core_clk),
      .wr_en(gpr_wr),
      .waddr(gpr_idx),
      .wdata(reg_wdata),
      .raddr(gpr_idx),
      .rdata(gpr_rdata)
   );

   // ----------------------------------------
   // program store, on its own port
   // ----------------------------------------
   cmm_prog_store #(
      .AW(PM_AW),
      .DW(PM_DW)
   ) u_prog (
      .core_clk(core_clk),
      .reset(reset),
      .load_en(pm_load),
      .load_addr(pm_load_addr),
      .load_data(pm_load_data),
      .fetch_addr(pc_r[PM_AW-1:0]),
      .fetch_word_r(instr_word)
   );

   // ----------------------------------------
   // program counter
   // ----------------------------------------
   // interrupt beats a branch, a branch beats a low-byte write
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         pc_r <= RESET_VEC;
      end
      else if (irq_take)
      begin
         pc_r <= IRQ_VEC;
      end
      else if (pc_load)
      begin
         pc_r <= pc_load_val;
      end
      else if (reg_wr && is_core && ofs == OFS_PCL)
      begin
         pc_r <= {pc_upper_latch_r, reg_wdata};
      end
      else if (pc_step)
      begin
         pc_r <= pc_r + 13'h0001;
      end
   end

   // ----------------------------------------
   // core registers
   // ----------------------------------------
   // power-down and time-out flags are not writable
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         core_status_r <= STATUS_RST;
      end
      else if (reg_wr && is_core && ofs == OFS_STATUS)
      begin
         core_status_r <= (reg_wdata & ST_WMASK) | (core_status_r & ~ST_WMASK);
      end
   end

   // pointer for indirect access
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         indirect_pointer_r <= PTR_RST;
      end
      else if (reg_wr && is_core && ofs == OFS_PTR)
      begin
         indirect_pointer_r <= reg_wdata;
      end
   end

   // upper program counter bits wait here until a low-byte write
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         pc_upper_latch_r <= LATCH_RST;
      end
      else if (reg_wr && is_core && ofs == OFS_LATCH)
      begin
         pc_upper_latch_r <= reg_wdata[4:0];
      end
   end

   // interrupt control storage only; no sources live here
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         interrupt_control_r <= INTERRUPT_CONTROL_RST;
      end
      else if (reg_wr && is_core && ofs == OFS_INTERRUPT_CONTROL)
      begin
         interrupt_control_r <= reg_wdata;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb
   begin
      rd_value = 8'h00;
      if (gpr_hit)
      begin
         rd_value = gpr_rdata;
      end
      else if (is_core)
      begin
         case (ofs)
            OFS_PCL: rd_value = pc_r[7:0];
            OFS_STATUS: rd_value = core_status_r;
            OFS_PTR: rd_value = indirect_pointer_r;
            OFS_LATCH: rd_value = {3'h0, pc_upper_latch_r};
            OFS_INTERRUPT_CONTROL: rd_value = interrupt_control_r;
            default: rd_value = 8'h00;
         endcase
      end
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         reg_rdata_r <= 8'h00;
      end
      else
      begin
         reg_rdata_r <= reg_rd ? rd_value : 8'h00;
      end
   end

   assign reg_rdata = reg_rdata_r;
   assign pc = pc_r;
   assign bank_sel = core_status_r[ST_BANK_HI:ST_BANK_LO];
   assign interrupt_control = interrupt_control_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence gpr_wr_s;
      reg_wr && gpr_hit && !irq_take;
   endsequence

   sequence rd_back_s;
      reg_rd && reg_addr == $past(reg_addr) && core_status_r == $past(core_status_r);
   endsequence

   irq_vector_a: assert property (@(posedge core_clk) disable iff (reset)
      irq_take |=> pc_r == IRQ_VEC)
      else $error("interrupt did not branch to vector");

   pcl_write_a: assert property (@(posedge core_clk) disable iff (reset)
      (reg_wr && is_core && ofs == OFS_PCL && !irq_take && !pc_load)
      |=> pc_r == {$past(pc_upper_latch_r), $past(reg_wdata)})
      else $error("low-byte write did not load program counter");

   pc_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
      (pc_step && !irq_take && !pc_load && !reg_wr && pc_r == 13'h07ff)
      |=> pc_r[PM_AW-1:0] == 11'h000)
      else $error("fetch index did not wrap");

   dual_bus_a: assert property (@(posedge core_clk) disable iff (reset)
      (pc_step && !irq_take && !pc_load && reg_wr && bank_ok && reg_addr == OFS_PTR)
      |=> pc_r == $past(pc_r) + 13'h0001 && indirect_pointer_r == $past(reg_wdata))
      else $error("simultaneous accesses interfered");

   bank_pick_a: assert property (@(posedge core_clk) disable iff (reset)
      (reg_rd && reg_addr != OFS_INDIRECT && core_status_r[ST_BANK_HI]) |=> reg_rdata_r == 8'h00)
      else $error("unimplemented bank did not read zero");

   unused_zero_a: assert property (@(posedge core_clk) disable iff (reset)
      (reg_rd && !gpr_hit && !is_core) |=> reg_rdata_r == 8'h00)
      else $error("unimplemented location did not read zero");

   mirror_ptr_a: assert property (@(posedge core_clk) disable iff (reset)
      (reg_wr && reg_addr == OFS_PTR && core_status_r[ST_BANK_HI:ST_BANK_LO] == 2'b01)
      |=> indirect_pointer_r == $past(reg_wdata))
      else $error("mirrored register missed in bank 1");

   gpr_hold_a: assert property (@(posedge core_clk) disable iff (reset)
      gpr_wr_s ##1 rd_back_s |=> reg_rdata_r == $past(reg_wdata, 2))
      else $error("ram did not return written byte");

   read_once_a: assert property (@(posedge core_clk) disable iff (reset)
      !reg_rd |=> reg_rdata_r == 8'h00)
      else $error("read data held beyond one cycle");
endmodule

// *** verification/core_memory_map_decode_tb_top.sv ***
// self-checking bench for the core memory map decode
`timescale 1ns/1ps
module core_memory_map_decode_tb_top;
   import cmm_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic pc_step = 1'b0;
   logic pc_load = 1'b0;
   logic irq_take = 1'b0;
   logic pm_load = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [12:0] pc_load_val = 13'h0000;
   logic [10:0] pm_load_addr = 11'h000;
   logic [13:0] pm_load_data = 14'h0000;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [7:0] interrupt_control;
   logic [12:0] pc;
   logic [13:0] instr_word;
   logic [1:0] bank_sel;
   logic [13:0] pm_m [0:2047];
   logic [7:0] ram_m [0:255];
   logic [6:0] a0 [0:7];
   logic [6:0] a;
   logic [7:0] d;
   int mismatches = 0;
   int checks = 0;

   // 100 ns core clock
   always #50 core_clk = ~core_clk;

   cmm_core_mem #(.GPR_WORDS(128)) i_cmm_core_mem (.core_clk(core_clk), .reset(reset),
      .pc_step(pc_step), .pc_load(pc_load), .pc_load_val(pc_load_val), .irq_take(irq_take),
      .pm_load(pm_load), .pm_load_addr(pm_load_addr), .pm_load_data(pm_load_data),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pc(pc), .instr_word(instr_word), .bank_sel(bank_sel),
      .interrupt_control(interrupt_control));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // status readback: bits 4:3 keep their reset value, writes cannot reach them
   function automatic logic [7:0] st_exp(input logic [7:0] w);
      return (w & ST_WMASK) | (STATUS_RST & ~ST_WMASK);
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // strobes drop and one edge passes, so no signal is assigned twice in a step
   task automatic wr(input logic [6:0] ad, input logic [7:0] v);
      reg_addr <= ad;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   // read data stands only in the cycle after the read edge
   task automatic rc(input logic [6:0] ad, input logic [7:0] e);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e, "register read");
      @(posedge core_clk);
   endtask

   // write and read of one location on two edges with no gap between the strobes
   task automatic wr_rc(input logic [6:0] ad, input logic [7:0] v);
      reg_addr <= ad;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, v, "write then read");
      @(posedge core_clk);
   endtask

   task automatic pml(input logic [10:0] ad, input logic [13:0] v);
      pm_m[ad] = v;
      pm_load_addr <= ad;
      pm_load_data <= v;
      pm_load <= 1'b1;
      @(posedge core_clk);
      pm_load <= 1'b0;
      @(posedge core_clk);
   endtask

   // third edge leaves pc and the fetched word settled
   task automatic jump(input logic [12:0] v, input logic irq);
      pc_load_val <= v;
      pc_load <= !irq;
      irq_take <= irq;
      @(posedge core_clk);
      pc_load <= 1'b0;
      irq_take <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   task automatic end_of_test;
      $display("TB: %0d checks, %0d mismatches", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // hang guard
   initial
   begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      end_of_test;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(21471));
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      chk(pc, RESET_VEC, "reset pc");
      chk(bank_sel, 2'b00, "reset bank");
      chk(interrupt_control, INTERRUPT_CONTROL_RST, "reset intctl");
      rc(OFS_STATUS, STATUS_RST);
      $display("TB: reset test done");
      for (int k = 0; k < 8; k++)
         pml(11'(k), 14'($urandom));
      pml(11'h7ff, 14'($urandom));
      jump(13'h07ff, 1'b0);
      chk(instr_word, pm_m[11'h7ff], "top word");
      pc_step <= 1'b1;
      repeat (2) @(posedge core_clk);
      pc_step <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(pc, 13'h0801, "step past top");
      chk(instr_word, pm_m[1], "wrapped fetch");
      jump(13'h1806, 1'b0);
      chk(instr_word, pm_m[6], "high wrap");
      jump(13'h0002, 1'b1);
      chk(pc, IRQ_VEC, "irq vector");
      chk(instr_word, pm_m[4], "irq fetch");
      $display("TB: program test done");
      // bank 0 ram while the fetch side keeps stepping
      jump(13'h0000, 1'b0);
      pc_step <= 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         a0[k] = 7'($urandom_range(127, 32));
         d = 8'($urandom);
         ram_m[{1'b0, a0[k]}] = d;
         wr(a0[k], d);
         rc(a0[k], d);
      end
      // pointer write in the same cycles as program steps
      wr(OFS_PTR, 8'h5a);
      rc(OFS_PTR, 8'h5a);
      pc_step <= 1'b0;
      #1;
      chk(pc, 13'h0024, "pc ran beside data");
      @(posedge core_clk);
      // bank 1 ram, mirrors and indirect access
      wr(OFS_STATUS, 8'h20);
      chk(bank_sel, 2'b01, "bank one");
      rc(OFS_STATUS, st_exp(8'h20));
      for (int k = 0; k < 8; k++)
      begin
         a = 7'($urandom_range(63, 32));
         d = 8'($urandom);
         wr_rc(a, d);
      end
      rc(7'h40, 8'h00);
      wr(OFS_PTR, 8'ha7);
      d = 8'($urandom);
      wr(OFS_INDIRECT, d);
      rc(7'h27, d);
      wr(OFS_STATUS, 8'h00);
      rc(OFS_PTR, 8'ha7);
      rc(OFS_INDIRECT, d);
      for (int k = 0; k < 8; k++)
         rc(a0[k], ram_m[{1'b0, a0[k]}]);
      wr(OFS_PTR, 8'h00);
      rc(OFS_INDIRECT, 8'h00);
      $display("TB: data test done");
      // program counter registers and interrupt control
      wr(OFS_LATCH, 8'hff);
      rc(OFS_LATCH, 8'h1f);
      wr(OFS_LATCH, 8'h03);
      wr(OFS_PCL, 8'h5c);
      chk(pc, 13'h035c, "pcl write");
      rc(OFS_PCL, 8'h5c);
      wr(OFS_INTERRUPT_CONTROL, 8'ha5);
      chk(interrupt_control, 8'ha5, "intctl");
      rc(7'h01, 8'h00);
      // upper bank bit set on purpose: bank 2 decodes nothing, so this runs last
      // and a second reset recovers
      wr(OFS_STATUS, 8'h40);
      chk(bank_sel, 2'b10, "bank two");
      rc(OFS_STATUS, 8'h00);
      rc(a0[0], 8'h00);
      reset <= 1'b1;
      @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      chk(pc, RESET_VEC, "second reset pc");
      chk(bank_sel, 2'b00, "second reset bank");
      rc(a0[0], ram_m[{1'b0, a0[0]}]);
      $display("TB: register test done");
      end_of_test;
   end
endmodule
